// >>> verilog/ccs_pkg.sv
// ccs_pkg: register map, field positions and shared types of the calendar clock core.
// assumes a 32-bit AHB-Lite slave, 16-bit registers in the low half of each word.
package ccs_pkg;
	localparam logic [7:0] CCS_OFF_CTRL   = 8'h00;
	localparam logic [7:0] CCS_OFF_SEC    = 8'h04;
	localparam logic [7:0] CCS_OFF_ALM1   = 8'h40;
	localparam logic [7:0] CCS_OFF_ALM2   = 8'h44;
	localparam logic [7:0] CCS_OFF_SWCTL  = 8'h48;
	localparam logic [7:0] CCS_OFF_FLAGS  = 8'h4C;
	localparam logic [7:0] CCS_OFF_ENA    = 8'h50;
	// zone z (0..2) sits at 0x10*(z+1); word 0 hour/minute, 1 month/day, 2 year/weekday
	localparam logic [1:0] CCS_ZW_HM      = 2'h0;
	localparam logic [1:0] CCS_ZW_MD      = 2'h1;
	localparam logic [1:0] CCS_ZW_YW      = 2'h2;
	localparam int         CCS_ZONES      = 3;
	// clock_control bits
	localparam int CCS_B_RUN   = 0;
	localparam int CCS_B_RST   = 1;
	localparam int CCS_B_ADJ   = 2;
	localparam int CCS_B_H24   = 4;
	localparam int CCS_B_HOLD  = 5;
	localparam int CCS_B_BUSY  = 6;
	localparam int CCS_B_TRIM  = 8;
	localparam int CCS_B_TBSY  = 15;
	// stopwatch_control bits
	localparam int CCS_B_SWGO  = 0;
	localparam int CCS_B_SWCLR = 4;
	// irq_flags / irq_enables bits
	localparam int CCS_F_S32   = 0;
	localparam int CCS_F_S8    = 1;
	localparam int CCS_F_S4    = 2;
	localparam int CCS_F_S2    = 3;
	localparam int CCS_F_SEC   = 4;
	localparam int CCS_F_MIN   = 5;
	localparam int CCS_F_HOUR  = 6;
	localparam int CCS_F_DAY   = 7;
	localparam int CCS_F_ALARM = 8;
	localparam int CCS_F_SW100 = 9;
	localparam int CCS_F_SW10  = 10;
	localparam int CCS_F_SW1   = 11;
	localparam int CCS_F_TRIM  = 12;
	localparam int CCS_NFLAGS  = 13;
	// timing: hclk rate and sub-second rates
	localparam longint CCS_HCLK_HZ  = 125000000;
	localparam longint CCS_SUB_HZ   = 256;
	localparam longint CCS_SW_HZ    = 100;
	localparam int CCS_DIV256 = int'(CCS_HCLK_HZ / CCS_SUB_HZ);
	localparam int CCS_DIV100 = int'(CCS_HCLK_HZ / CCS_SW_HZ);
	localparam logic [7:0] CCS_SUB_TRIM_AT = 8'h7F;
	localparam logic [7:0] CCS_SUB_LAST    = 8'hFF;
	localparam logic [6:0] CCS_SEC_HALF    = 7'd30;
	localparam logic [6:0] CCS_SEC_MAX     = 7'd59;
	localparam logic [6:0] CCS_MIN_MAX     = 7'd59;
	localparam logic [6:0] CCS_H24_MAX     = 7'd23;
	localparam logic [6:0] CCS_H12_MAX     = 7'd12;
	localparam logic [6:0] CCS_H12_PRE     = 7'd11;
	localparam logic [6:0] CCS_MON_MAX     = 7'd12;
	localparam logic [6:0] CCS_FEB         = 7'd2;
	localparam logic [6:0] CCS_YEAR_MAX    = 7'd99;
	localparam logic [6:0] CCS_WEEK_MAX    = 7'd6;
	localparam logic [3:0] CCS_DIG_MAX     = 4'h9;

	typedef struct packed {
		logic [6:0] min;
		logic [5:0] hour;
		logic       pm;
		logic [5:0] day;
		logic [4:0] mon;
		logic [7:0] year;
		logic [2:0] week;
	} ccs_zone_t;

	typedef struct packed {
		ccs_zone_t z;
		logic      hour_up;
		logic      day_up;
	} ccs_zres_t;
endpackage

// >>> verilog/ccs_core.sv
// ccs_core: calendar time-of-day counter with three zones, stopwatch, alarm,
// event flags and rate trim, as an AHB-Lite slave with zero wait states.
// assumes one slave on the bus, word transfers only, hclk at 125 MHz.
// How it works
// - one seconds counter, three zones stepped
// - year divisible by four is leap, except 00
// - February gets 29 days in leap years
// - out-of-range values forced at count-up
// - half-minute adjust rounds seconds to minute
// - tick during hold gives one catch-up second
// - catch-up is exactly one second, however many
// - alarm and calendar flags, write-one clears
// - stopwatch flags on digit steps, write-one clears
// - trim completion flag, write-one clears
// - sub-second flags one sub-tick after change
// - alarm flag one sub-tick after match
// - interrupt only for enabled set flags
// - trim write sets busy, ends within second
// - trim writes ignored while busy, reads zero
// - zero trim sets busy, changes nothing
// - count busy for one sub-tick after steps
// - hold freezes time counters for reading
// - hold forced low while trim busy
// - hour mode changes range only, no conversion
// - adjust done within two sub-ticks, self-clears
// - run bit stops and resumes counters
// - signed trim applied when sub-second hits 7F
// - sub-second reset clears counter, adjust, hold
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module ccs_core
#(
	parameter int DIV256 = ccs_pkg::CCS_DIV256,
	parameter int DIV100 = ccs_pkg::CCS_DIV100
)
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// outputs to the system
	output logic             irq,
	output logic             one_hz_tick
);
	import ccs_pkg::*;

	typedef struct packed {
		logic [6:0] n;
		logic       c;
	} ccs_step_t;

	function automatic logic [6:0] b2n(input logic [7:0] b);
		b2n = 7'(b[7:4] * 4'd10) + 7'(b[3:0]);
	endfunction

	function automatic logic [7:0] n2b(input logic [6:0] n);
		n2b = {4'(n / 7'd10), 4'(n % 7'd10)};
	endfunction

	// fix an out-of-range value to lo, otherwise optionally count with wrap
	function automatic ccs_step_t bstep(input logic [6:0] n, input logic [6:0] lo,
		input logic [6:0] hi, input logic inc);
		ccs_step_t r;
		r.n = n;
		r.c = 1'b0;
		if (n < lo || n > hi)
			r.n = lo;
		else if (inc && n == hi)
		begin
			r.n = lo;
			r.c = 1'b1;
		end
		else if (inc)
			r.n = n + 7'd1;
		bstep = r;
	endfunction

	function automatic logic [6:0] days_in(input logic [6:0] mon, input logic [6:0] yr);
		logic leap;
		leap = (yr[1:0] == 2'b00) && (yr != 7'd0);
		case (mon)
			7'd4, 7'd6, 7'd9, 7'd11: days_in = 7'd30;
			7'd2:                    days_in = leap ? 7'd29 : 7'd28;
			default:                 days_in = 7'd31;
		endcase
	endfunction

	// one count-up step of a zone; cin carries a minute overflow in
	function automatic ccs_zres_t zstep(input ccs_zone_t z, input logic cin, input logic h24);
		ccs_zres_t r;
		ccs_step_t s;
		ccs_step_t d;
		logic [6:0] h;
		logic [6:0] mo;
		logic       nday;
		logic [7:0] bcd;
		r.z = z;
		s = bstep(b2n({1'b0, z.min}), 7'd0, CCS_MIN_MAX, cin);
		bcd = n2b(s.n);
		r.z.min = bcd[6:0];
		r.hour_up = s.c;
		h = b2n({2'b00, z.hour});
		nday = 1'b0;
		if (h24)
		begin
			s = bstep(h, 7'd0, CCS_H24_MAX, r.hour_up);
			nday = s.c;
		end
		else
		begin
			s = bstep(h, 7'd1, CCS_H12_MAX, r.hour_up);
			if (r.hour_up && h == CCS_H12_PRE)
			begin
				r.z.pm = ~z.pm;
				nday = z.pm;
			end
		end
		bcd = n2b(s.n);
		r.z.hour = bcd[5:0];
		r.day_up = nday;
		mo = b2n({3'b000, z.mon});
		d = bstep(b2n({2'b00, z.day}), 7'd1, days_in(mo, b2n(z.year)), nday);
		bcd = n2b(d.n);
		r.z.day = bcd[5:0];
		s = bstep(b2n({5'b00000, z.week}), 7'd0, CCS_WEEK_MAX, nday);
		bcd = n2b(s.n);
		r.z.week = bcd[2:0];
		s = bstep(mo, 7'd1, CCS_MON_MAX, d.c);
		bcd = n2b(s.n);
		r.z.mon = bcd[4:0];
		s = bstep(b2n(z.year), 7'd0, CCS_YEAR_MAX, s.c);
		r.z.year = n2b(s.n);
		zstep = r;
	endfunction

	// registers
	ccs_zone_t           zone_reg [CCS_ZONES];
	logic [6:0]          sec_reg;
	logic [7:0]          sub_reg;
	logic                run_reg, rst_reg, adj_reg, h24_reg, hold_reg, busy_reg;
	logic                tbusy_reg;
	logic [6:0]          trim_reg;
	logic                pend_reg;
	logic [6:0]          asec_reg;
	logic [14:0]         ahm_reg;
	logic [3:0]          tenths_reg, hund_reg;
	logic                swgo_reg;
	logic [CCS_NFLAGS-1:0] flags_reg, ena_reg, dly_reg;
	logic                match_reg;
	logic [31:0]         div256_reg, div100_reg;
	logic                dph_reg, dwr_reg;
	logic [7:0]          daddr_reg;

	// bus decode: address phase captured, write applied in data phase
	logic aphase;
	assign aphase = hsel && hready && htrans[1];
	logic wr;
	assign wr = dph_reg && dwr_reg;
	logic [15:0] wd;
	assign wd = hwdata[15:0];
	logic wr_ctrl, wr_sec, wr_alm1, wr_alm2, wr_sw, wr_flags, wr_ena;
	assign wr_ctrl  = wr && daddr_reg == CCS_OFF_CTRL;
	assign wr_sec   = wr && daddr_reg == CCS_OFF_SEC;
	assign wr_alm1  = wr && daddr_reg == CCS_OFF_ALM1;
	assign wr_alm2  = wr && daddr_reg == CCS_OFF_ALM2;
	assign wr_sw    = wr && daddr_reg == CCS_OFF_SWCTL;
	assign wr_flags = wr && daddr_reg == CCS_OFF_FLAGS;
	assign wr_ena   = wr && daddr_reg == CCS_OFF_ENA;

	// time base
	logic tick256, tick100;
	assign tick256 = div256_reg == 32'(DIV256 - 1);
	assign tick100 = div100_reg == 32'(DIV100 - 1);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div256_reg <= 32'h0000_0000;
			div100_reg <= 32'h0000_0000;
		end
		else
		begin
			div256_reg <= tick256 ? 32'h0000_0000 : div256_reg + 32'h0000_0001;
			div100_reg <= tick100 ? 32'h0000_0000 : div100_reg + 32'h0000_0001;
		end
	end

	// sub-second counter with trim
	logic [7:0] sub_inc;
	assign sub_inc = sub_reg + 8'h01;
	logic sub_adv, sec_wrap, trim_hit;
	assign sub_adv  = tick256 && run_reg;
	assign sec_wrap = sub_adv && sub_reg == CCS_SUB_LAST;
	assign trim_hit = sub_adv && sub_inc == CCS_SUB_TRIM_AT && tbusy_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sub_reg <= 8'h00;
		else if (rst_reg)
			sub_reg <= 8'h00;
		else if (trim_hit)
			sub_reg <= sub_inc + {trim_reg[6], trim_reg};
		else if (sub_adv)
			sub_reg <= sub_inc;
	end

	// second stepping: normal tick, single catch-up, half-minute adjust
	logic do_adj, do_step, cmin;
	assign do_adj  = tick256 && adj_reg;
	assign do_step = tick256 && !hold_reg && !adj_reg && (sec_wrap || pend_reg);
	ccs_step_t sstep;
	assign sstep = bstep(b2n({1'b0, sec_reg}), 7'd0, CCS_SEC_MAX, 1'b1);
	logic [7:0] sec_bcd;
	assign sec_bcd = n2b(sstep.n);
	assign cmin = do_adj ? (b2n({1'b0, sec_reg}) >= CCS_SEC_HALF) : (do_step && sstep.c);
	ccs_zres_t zr [CCS_ZONES];
	for (genvar g = 0; g < CCS_ZONES; g++)
	begin : g_zone
		assign zr[g] = zstep(zone_reg[g], cmin, h24_reg);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pend_reg <= 1'b0;
		else if (sec_wrap && hold_reg)
			pend_reg <= 1'b1;
		else if (do_step)
			pend_reg <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sec_reg <= 7'h00;
		else if (wr_sec)
			sec_reg <= wd[14:8];
		else if (do_adj)
			sec_reg <= 7'h00;
		else if (do_step)
			sec_reg <= sec_bcd[6:0];
	end

	// zone word layout: hm {0,pm,hour,0,min}, md {0,mon,0,day}, yw {year,0,week}
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < CCS_ZONES; i++)
				zone_reg[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < CCS_ZONES; i++)
			begin
				if (wr && daddr_reg[7:4] == 4'(i + 1) && daddr_reg[3:2] == CCS_ZW_HM)
				begin
					zone_reg[i].min  <= wd[6:0];
					zone_reg[i].hour <= wd[13:8];
					zone_reg[i].pm   <= wd[14];
				end
				else if (wr && daddr_reg[7:4] == 4'(i + 1) && daddr_reg[3:2] == CCS_ZW_MD)
				begin
					zone_reg[i].day <= wd[5:0];
					zone_reg[i].mon <= wd[12:8];
				end
				else if (wr && daddr_reg[7:4] == 4'(i + 1) && daddr_reg[3:2] == CCS_ZW_YW)
				begin
					zone_reg[i].week <= wd[2:0];
					zone_reg[i].year <= wd[15:8];
				end
				else if (do_step || do_adj)
					zone_reg[i] <= zr[i].z;
			end
		end
	end

	// control register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			run_reg   <= 1'b0;
			rst_reg   <= 1'b0;
			adj_reg   <= 1'b0;
			h24_reg   <= 1'b0;
			hold_reg  <= 1'b0;
			tbusy_reg <= 1'b0;
			trim_reg  <= 7'h00;
		end
		else
		begin
			rst_reg <= wr_ctrl && wd[CCS_B_RST];
			if (wr_ctrl)
			begin
				run_reg <= wd[CCS_B_RUN];
				h24_reg <= wd[CCS_B_H24];
			end
			if (rst_reg)
				adj_reg <= 1'b0;
			else if (wr_ctrl && wd[CCS_B_ADJ])
				adj_reg <= 1'b1;
			else if (do_adj)
				adj_reg <= 1'b0;
			if (rst_reg || tbusy_reg)
				hold_reg <= 1'b0;
			else if (wr_ctrl)
				hold_reg <= wd[CCS_B_HOLD];
			if (wr_ctrl && !tbusy_reg)
			begin
				trim_reg  <= wd[CCS_B_TRIM +: 7];
				tbusy_reg <= 1'b1;
			end
			else if (trim_hit)
				tbusy_reg <= 1'b0;
		end
	end

	// count busy lasts until the next sub-second tick
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			busy_reg <= 1'b0;
		else if (do_step || do_adj)
			busy_reg <= 1'b1;
		else if (tick256)
			busy_reg <= 1'b0;
	end

	// alarm and stopwatch
	logic amatch;
	assign amatch = asec_reg == sec_reg && ahm_reg[6:0] == zone_reg[0].min
		&& ahm_reg[13:8] == zone_reg[0].hour && (h24_reg || ahm_reg[14] == zone_reg[0].pm);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			asec_reg <= 7'h00;
			ahm_reg  <= 15'h0000;
		end
		else
		begin
			if (wr_alm1)
				asec_reg <= wd[14:8];
			if (wr_alm2)
				ahm_reg <= wd[14:0];
		end
	end

	logic sw_h, sw_t, sw_o;
	assign sw_h = tick100 && swgo_reg;
	assign sw_t = sw_h && hund_reg == CCS_DIG_MAX;
	assign sw_o = sw_t && tenths_reg == CCS_DIG_MAX;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			swgo_reg   <= 1'b0;
			hund_reg   <= 4'h0;
			tenths_reg <= 4'h0;
		end
		else
		begin
			if (wr_sw)
				swgo_reg <= wd[CCS_B_SWGO];
			if (wr_sw && wd[CCS_B_SWCLR])
			begin
				hund_reg   <= 4'h0;
				tenths_reg <= 4'h0;
			end
			else if (sw_h)
			begin
				hund_reg <= sw_t ? 4'h0 : hund_reg + 4'h1;
				if (sw_t)
					tenths_reg <= sw_o ? 4'h0 : tenths_reg + 4'h1;
			end
		end
	end

	// event flags: sub-second and one-second events wait one sub-tick
	logic [CCS_NFLAGS-1:0] now_set, dly_set, clr;
	always_comb
	begin
		dly_set = '0;
		dly_set[CCS_F_S32]   = sub_adv && sub_inc[2:0] == 3'h0;
		dly_set[CCS_F_S8]    = sub_adv && sub_inc[4:0] == 5'h00;
		dly_set[CCS_F_S4]    = sub_adv && sub_inc[5:0] == 6'h00;
		dly_set[CCS_F_S2]    = sub_adv && sub_inc[6:0] == 7'h00;
		dly_set[CCS_F_SEC]   = do_step || do_adj;
		now_set = '0;
		// match is sampled at sub-ticks, which already gives the one sub-tick lag
		now_set[CCS_F_ALARM] = tick256 && amatch && !match_reg;
		now_set[CCS_F_MIN]   = cmin;
		now_set[CCS_F_HOUR]  = (do_step || do_adj) && zr[0].hour_up;
		now_set[CCS_F_DAY]   = (do_step || do_adj) && zr[0].day_up;
		now_set[CCS_F_SW100] = sw_h;
		now_set[CCS_F_SW10]  = sw_t;
		now_set[CCS_F_SW1]   = sw_o;
		now_set[CCS_F_TRIM]  = trim_hit;
		clr = wr_flags ? wd[CCS_NFLAGS-1:0] : '0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			flags_reg <= '0;
			dly_reg   <= '0;
			match_reg <= 1'b0;
			ena_reg   <= '0;
			irq       <= 1'b0;
		end
		else
		begin
			if (tick256)
				match_reg <= amatch;
			dly_reg <= tick256 ? dly_set : dly_reg;
			// set wins over a simultaneous write-one clear
			flags_reg <= (flags_reg & ~clr) | now_set | (tick256 ? dly_reg : '0);
			if (wr_ena)
				ena_reg <= wd[CCS_NFLAGS-1:0];
			irq <= |(flags_reg & ena_reg);
		end
	end

	// read mux, registered in the address phase so data stands in the data phase
	logic [15:0] rd;
	ccs_zone_t   rz;
	always_comb
	begin
		rz = zone_reg[0];
		for (int i = 0; i < CCS_ZONES; i++)
			if (haddr[7:4] == 4'(i + 1))
				rz = zone_reg[i];
		rd = 16'h0000;
		case (haddr[7:0])
			CCS_OFF_CTRL:
				rd = {tbusy_reg, 7'h00, 1'b0, busy_reg, hold_reg, h24_reg, 1'b0, adj_reg,
					rst_reg, run_reg};
			CCS_OFF_SEC:   rd = {1'b0, sec_reg, sub_reg};
			CCS_OFF_ALM1:  rd = {1'b0, asec_reg, 8'h00};
			CCS_OFF_ALM2:  rd = {1'b0, ahm_reg[14:8], 1'b0, ahm_reg[6:0]};
			CCS_OFF_SWCTL: rd = {tenths_reg, hund_reg, 7'h00, swgo_reg};
			CCS_OFF_FLAGS: rd = 16'(flags_reg);
			CCS_OFF_ENA:   rd = 16'(ena_reg);
			default:
			begin
				if (haddr[7:4] != 4'h0 && haddr[7:4] <= 4'(CCS_ZONES) && haddr[1:0] == 2'b00)
				begin
					case (haddr[3:2])
						CCS_ZW_HM: rd = {1'b0, rz.pm, rz.hour, 1'b0, rz.min};
						CCS_ZW_MD: rd = {3'h0, rz.mon, 2'h0, rz.day};
						CCS_ZW_YW: rd = {rz.year, 5'h00, rz.week};
						default:   rd = 16'h0000;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_reg     <= 1'b0;
			dwr_reg     <= 1'b0;
			daddr_reg   <= 8'h00;
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b0;
			hresp       <= 1'b0;
			one_hz_tick <= 1'b0;
		end
		else
		begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			dph_reg     <= aphase;
			dwr_reg     <= aphase && hwrite;
			one_hz_tick <= sub_reg[7];
			if (aphase)
			begin
				daddr_reg <= haddr[7:0];
				hrdata    <= hwrite ? 32'h0000_0000 : {16'h0000, rd};
			end
		end
	end
endmodule

// >>> testbench/ccs_core_checker.sv
// ccs_core_checker: port-level timing and read-back assertions for the core.
// assumes one clock domain and hready looped back from hreadyout.
`timescale 1ns/1ns
module ccs_core_checker
(
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// ahb-lite slave
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// system outputs
	input wire logic        irq,
	input wire logic        one_hz_tick
);
	import ccs_pkg::*;
	logic acc;
	logic rd;
	assign acc = hsel && hready && htrans[1];
	assign rd  = acc && !hwrite;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	okay_resp_a: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	ready_up_a: assert property ($past(hresetn) |-> hreadyout)
		else $error("hreadyout low after reset");
	reset_quiet_a: assert property ($rose(hresetn) |-> !irq && !one_hz_tick && hrdata == 32'h0)
		else $error("outputs not cleared by reset");
	upper_zero_a: assert property (hrdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	rdata_hold_a: assert property (!acc |=> $stable(hrdata))
		else $error("hrdata moved without a transfer");
	unmapped_zero_a: assert property (rd && haddr[7:0] >= 8'h60 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	ctrl_rsvd_a: assert property (rd && haddr[7:0] == CCS_OFF_CTRL
		|=> hrdata[14:8] == 7'h0 && !hrdata[7] && !hrdata[3])
		else $error("control trim or reserved bits read nonzero");
	sw_rsvd_a: assert property (rd && haddr[7:0] == CCS_OFF_SWCTL |=> hrdata[7:1] == 7'h0)
		else $error("stopwatch reserved bits nonzero");
	sec_bcd_a: assert property (rd && haddr[7:0] == CCS_OFF_SEC
		|=> !hrdata[15] && hrdata[14:12] <= 3'h5 && hrdata[11:8] <= 4'h9)
		else $error("seconds not valid bcd");
	tick_steady_a: assert property ($changed(one_hz_tick) |=> $stable(one_hz_tick) [*8])
		else $error("one second output toggles too fast");

	irq_seen_c: cover property ($rose(irq));
	tick_seen_c: cover property ($rose(one_hz_tick));
	ctrl_read_c: cover property (rd && haddr[7:0] == CCS_OFF_CTRL);
endmodule

bind ccs_core ccs_core_checker u_ccs_core_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
	.one_hz_tick(one_hz_tick));

// >>> testbench/test_ccs_core.sv
// test_ccs_core: self-checking bench driving the core as its only ahb-lite master.
// assumes hready loops back from hreadyout; small dividers make one second 1024 cycles.
`timescale 1ns/1ns
module test_ccs_core;
	import ccs_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic        one_hz_tick;
	logic [15:0] rd;
	logic [15:0] prev;
	int          num_errors;
	int          comparisons;
	// zone words set, then expected zone words after the next step
	localparam logic [15:0] CAL_TBL [4][6] = '{
		'{16'h2359, 16'h1231, 16'h2306, 16'h0000, 16'h0101, 16'h2400},
		'{16'h2359, 16'h0228, 16'h2402, 16'h0000, 16'h0229, 16'h2403},
		'{16'h2359, 16'h0228, 16'h0002, 16'h0000, 16'h0301, 16'h0003},
		'{16'h0059, 16'h0110, 16'hA507, 16'h0100, 16'h0110, 16'h0000}};
	localparam logic [15:0] ADJ_TBL [2][2] = '{'{16'h4500, 16'h0011}, '{16'h2900, 16'h0011}};

	ccs_core #(.DIV256(4), .DIV100(6)) u_ccs_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
		.one_hz_tick(one_hz_tick));

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task finish_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				num_errors++;
				finish_test();
			end
			@(posedge hclk);
		end
	endtask

	// one single transfer; read data lands in rd at the end of the data phase
	task bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= {16'h0000, d};
		wait_ready();
		rd = hrdata[15:0];
	endtask

	task poll(input logic [7:0] a, input logic [15:0] m, input logic [15:0] v, input int lim);
		int n;
		n = 0;
		bus(1'b0, a, 16'h0000);
		while ((rd & m) !== v)
		begin
			n++;
			if (n > lim)
			begin
				num_errors++;
				finish_test();
			end
			bus(1'b0, a, 16'h0000);
		end
	endtask

	task test_reset;
		// flags first: the reset time matches the reset alarm one sub-tick later
		bus(1'b0, CCS_OFF_FLAGS, 16'h0000);
		check("flags", 16'h0000, rd);
		bus(1'b0, CCS_OFF_CTRL, 16'h0000);
		check("control", 16'h0000, rd);
		bus(1'b0, 8'h60, 16'h0000);
		check("unmapped", 16'h0000, rd);
		$display("test_reset done");
	endtask

	task test_trim;
		bus(1'b1, CCS_OFF_CTRL, 16'h7F11);
		bus(1'b0, CCS_OFF_CTRL, 16'h0000);
		check("trim busy", 16'h8011, rd & 16'hFFBF);
		// hold request and new trim value both ignored while busy
		bus(1'b1, CCS_OFF_CTRL, 16'h0531);
		bus(1'b0, CCS_OFF_CTRL, 16'h0000);
		check("hold while busy", 16'h8011, rd & 16'hFFBF);
		bus(1'b1, CCS_OFF_FLAGS, 16'h1FFF);
		poll(CCS_OFF_CTRL, 16'h8000, 16'h0000, 400);
		bus(1'b0, CCS_OFF_FLAGS, 16'h0000);
		check("trim done", 16'h1000, rd & 16'h1000);
		bus(1'b1, CCS_OFF_FLAGS, 16'h1000);
		bus(1'b0, CCS_OFF_FLAGS, 16'h0000);
		check("trim done clear", 16'h0000, rd & 16'h1000);
		$display("test_trim done");
	endtask

	task test_irq;
		bus(1'b0, CCS_OFF_FLAGS, 16'h0000);
		// the step to 00:00:00 also meets the reset alarm setting
		check("calendar flags", 16'h01FF, rd & 16'h01FF);
		bus(1'b1, CCS_OFF_ENA, 16'h0080);
		bus(1'b0, CCS_OFF_ENA, 16'h0000);
		check("enables", 16'h0080, rd);
		check("irq enabled", 16'h0001, {15'h0, irq});
		bus(1'b1, CCS_OFF_ENA, 16'h0000);
		bus(1'b0, CCS_OFF_ENA, 16'h0000);
		check("irq masked", 16'h0000, {15'h0, irq});
		bus(1'b1, CCS_OFF_ENA, 16'h0080);
		bus(1'b1, CCS_OFF_FLAGS, 16'h0080);
		bus(1'b0, CCS_OFF_FLAGS, 16'h0000);
		check("day flag clear", 16'h0000, rd & 16'h0080);
		check("irq cleared", 16'h0000, {15'h0, irq});
		bus(1'b1, CCS_OFF_ENA, 16'h0000);
		$display("test_irq done");
	endtask

	task test_calendar;
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, 8'h10, CAL_TBL[i][0]);
			bus(1'b1, 8'h14, CAL_TBL[i][1]);
			bus(1'b1, 8'h18, CAL_TBL[i][2]);
			bus(1'b1, CCS_OFF_SEC, 16'h5900);
			poll(CCS_OFF_SEC, 16'h7F00, 16'h0000, 500);
			// the sub-second counter has just wrapped: pin in its low half
			check("one second pin", 16'h0000, {15'h0, one_hz_tick});
			bus(1'b0, 8'h10, 16'h0000);
			check("hour minute", CAL_TBL[i][3], rd);
			bus(1'b0, 8'h14, 16'h0000);
			check("month day", CAL_TBL[i][4], rd);
			bus(1'b0, 8'h18, 16'h0000);
			check("year weekday", CAL_TBL[i][5], rd);
			if (i == 0)
				test_irq();
		end
		$display("test_calendar done");
	endtask

	task test_adjust;
		// stopped clock: the adjustment must still run
		// sub-second reset with the clock stopped: the counter must stay at zero
		bus(1'b1, CCS_OFF_CTRL, 16'h0012);
		bus(1'b1, 8'h10, 16'h0010);
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, CCS_OFF_SEC, ADJ_TBL[i][0]);
			bus(1'b1, CCS_OFF_CTRL, 16'h0014);
			poll(CCS_OFF_CTRL, 16'h0004, 16'h0000, 4);
			bus(1'b0, CCS_OFF_SEC, 16'h0000);
			check("adjust seconds", 16'h0000, rd);
			bus(1'b0, 8'h10, 16'h0000);
			check("adjust minute", ADJ_TBL[i][1], rd);
		end
		$display("test_adjust done");
	endtask

	task test_stopwatch;
		bus(1'b1, CCS_OFF_SWCTL, 16'h0010);
		bus(1'b1, CCS_OFF_FLAGS, 16'h0E00);
		bus(1'b1, CCS_OFF_ENA, 16'h0E00);
		bus(1'b1, CCS_OFF_SWCTL, 16'h0001);
		poll(CCS_OFF_FLAGS, 16'h0E00, 16'h0E00, 300);
		check("stopwatch irq", 16'h0001, {15'h0, irq});
		bus(1'b1, CCS_OFF_SWCTL, 16'h0000);
		// the counter may take one more step after stopping
		bus(1'b0, CCS_OFF_SWCTL, 16'h0000);
		bus(1'b0, CCS_OFF_SWCTL, 16'h0000);
		prev = rd;
		bus(1'b0, CCS_OFF_SWCTL, 16'h0000);
		check("stopwatch held", prev, rd);
		bus(1'b1, CCS_OFF_SWCTL, 16'h0010);
		bus(1'b0, CCS_OFF_SWCTL, 16'h0000);
		check("stopwatch clear", 16'h0000, rd);
		bus(1'b1, CCS_OFF_ENA, 16'h0000);
		$display("test_stopwatch done");
	endtask

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		num_errors = 0;
		comparisons = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		test_reset();
		test_trim();
		test_calendar();
		test_adjust();
		test_stopwatch();
		finish_test();
	end
endmodule
